//--- rtl/socs_pkg.sv
// socs_pkg: offsets, field positions, codes and reset values of the
// system option clock select block.
// assumes a 12-bit byte address window below the block's base.
package socs_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned NREG = 3;

  // register byte offsets
  localparam logic [11:0] OFS_CLKSRC = 12'h004;
  localparam logic [11:0] OFS_TMROPT = 12'h00c;
  localparam logic [11:0] OFS_SEROPT = 12'h010;

  // values after reset
  localparam logic [31:0] RST_CLKSRC = 32'h0000_0000;
  localparam logic [31:0] RST_TMROPT = 32'h0000_0000;
  localparam logic [31:0] RST_SEROPT = 32'h0000_0000;

  // writable bits of each register, all others read zero
  localparam logic [31:0] MASK_CLKSRC = 32'h0f00_00f0;
  localparam logic [31:0] MASK_TMROPT = 32'h0304_0000;
  localparam logic [31:0] MASK_SEROPT = 32'h0001_0000;

  // field positions
  localparam int unsigned SER_SRC_LSB = 26;
  localparam int unsigned TMR_SRC_LSB = 24;
  localparam int unsigned CKO_SEL_LSB = 5;
  localparam int unsigned RTCOUT_BIT = 4;
  localparam int unsigned T1PIN_BIT = 25;
  localparam int unsigned T0PIN_BIT = 24;
  localparam int unsigned CAP_BIT = 18;
  localparam int unsigned OD_BIT = 16;

  // peripheral clock source codes
  localparam logic [1:0] SRC_OFF = 2'h0;
  localparam logic [1:0] SRC_FAST_RC = 2'h1;
  localparam logic [1:0] SRC_OSC_REF = 2'h2;
  localparam logic [1:0] SRC_GEN_REF = 2'h3;

  // clock output pin codes, the rest are reserved
  localparam logic [2:0] CKO_BUS = 3'h2;
  localparam logic [2:0] CKO_LP_OSC = 3'h3;
  localparam logic [2:0] CKO_SLOW_RC = 3'h4;
  localparam logic [2:0] CKO_OSC_REF = 3'h6;
  localparam logic [2:0] CKO_FAST_RC = 3'h7;
  localparam logic [7:0] CKO_VALID = 8'hdc;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // one-hot register hit for a byte address
  function automatic logic [2:0] reg_hit(input logic [11:0] addr);
    reg_hit = {addr == OFS_SEROPT, addr == OFS_TMROPT, addr == OFS_CLKSRC};
  endfunction : reg_hit

endpackage : socs_pkg

//--- rtl/socs_wr_if.sv
// socs_wr_if: write strobe and data from the bus slave to one option register.
// assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface socs_wr_if;
  logic en;
  logic [31:0] data;
  logic [3:0] strb;
  modport src (output en, output data, output strb);
  modport dst (input en, input data, input strb);
endinterface : socs_wr_if
`default_nettype wire

//--- rtl/socs_opt_reg.sv
// socs_opt_reg: one 32-bit option register with byte strobes and a write mask.
// assumes the write port pulses en for one cycle per accepted write.
`timescale 1ns/1ps
`default_nettype none
module socs_opt_reg #(
  parameter logic [31:0] MASK = 32'hffff_ffff,
  parameter logic [31:0] RST = 32'h0000_0000
) (
  input wire logic i_clk,
  input wire logic i_rst,
  socs_wr_if.dst wr,
  output logic [31:0] o_q
);
  logic [31:0] q_r;
  logic [31:0] q_nxt;

  // per byte merge of new data, masked bits stay zero
  for (genvar b = 0; b < 4; b++) begin : g_byte
    wire logic sel = wr.en & wr.strb[b];
    assign q_nxt[b*8 +: 8] = (sel ? wr.data[b*8 +: 8] : q_r[b*8 +: 8]) & MASK[b*8 +: 8];
  end

  // storage
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q_r <= RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign o_q = q_r;
endmodule : socs_opt_reg
`default_nettype wire

//--- rtl/socs_clk_mux.sv
// socs_clk_mux: plain clock selector, not glitch free, with reserved codes.
// assumes the select only changes while the chosen sources are quiet or unused.
`timescale 1ns/1ps
`default_nettype none
module socs_clk_mux #(
  parameter int unsigned SEL_W = 2,
  parameter logic [(1<<SEL_W)-1:0] VALID = '1
) (
  input wire logic [SEL_W-1:0] i_sel,
  input wire logic [(1<<SEL_W)-1:0] i_src,
  output logic o_clk
);
  // a reserved or off code gives a static low
  assign o_clk = VALID[i_sel] & i_src[i_sel];
endmodule : socs_clk_mux
`default_nettype wire

//--- rtl/socs_clock_select.sv
// socs_clock_select: option registers that steer peripheral clocks,
// clock output pins, timer clock pins, capture source and open drain.
// assumes an AXI4-Lite master on i_clk and clock sources already in the
// chip; the muxes are combinational and switch with the register value.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
module socs_clock_select (
  input wire logic i_clk,
  input wire logic i_rst,
  // axi4-lite write address
  input wire logic [11:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  input wire logic i_awvalid,
  output logic o_awready,
  // axi4-lite write data
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // axi4-lite write response
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read address
  input wire logic [11:0] i_araddr,
  input wire logic [2:0] i_arprot,
  input wire logic i_arvalid,
  output logic o_arready,
  // axi4-lite read data
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // clock sources
  input wire logic i_fast_internal_rc_clock,
  input wire logic i_external_oscillator_ref_clock,
  input wire logic i_clock_generator_internal_ref,
  input wire logic i_slow_internal_rc_clock,
  input wire logic i_low_power_oscillator_1khz,
  input wire logic i_rtc_1hz_clock,
  // timer pins and capture sources
  input wire logic i_timer_ext_clock_input_0,
  input wire logic i_timer_ext_clock_input_1,
  input wire logic i_timer1_channel0_input,
  input wire logic i_analog_comparator_output,
  // serial transmit data from the serial port
  input wire logic i_serial_tx_data,
  // steered clocks
  output logic o_serial_port_clock,
  output logic o_timer_counter_clock,
  output logic o_general_clock_output_pin,
  output logic o_rtc_clock_output_pin,
  output logic o_timer0_ext_clock,
  output logic o_timer1_ext_clock,
  output logic o_timer1_ch0_capture,
  // serial transmit pin
  output logic o_serial_port_open_drain_enable,
  output logic o_serial_tx_pin_o,
  output logic o_serial_tx_pin_oe_n,
  // field values for the peripherals
  output logic [1:0] o_serial_port_clock_source,
  output logic [1:0] o_timer_counter_clock_source,
  output logic [2:0] o_clock_output_pin_select
);

  ////////////////////////////////////////////////////////////////////////
  // bus state

  typedef enum logic [0:0] {WS_COLLECT, WS_RESP} socs_wr_state_t;
  typedef enum logic [0:0] {RS_IDLE, RS_RESP} socs_rd_state_t;

  socs_wr_state_t ws_r;
  socs_wr_state_t ws_nxt;
  socs_rd_state_t rs_r;
  socs_rd_state_t rs_nxt;

  logic aw_held_r;
  logic aw_held_nxt;
  logic w_held_r;
  logic w_held_nxt;
  logic [11:0] aw_addr_r;
  logic [2:0] aw_prot_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_r;
  logic [1:0] rresp_nxt;
  logic tx_r;

  logic [socs_pkg::NREG-1:0][31:0] reg_q;

  ////////////////////////////////////////////////////////////////////////
  // write channel decode

  wire logic aw_take = i_awvalid & o_awready;
  wire logic w_take = i_wvalid & o_wready;
  wire logic both_held = (ws_r == WS_COLLECT) & aw_held_r & w_held_r;
  wire logic [2:0] wr_hit = socs_pkg::reg_hit(aw_addr_r);
  wire logic wr_mapped = |wr_hit;
  wire logic wr_priv = aw_prot_r[0];
  wire logic wr_do = both_held & wr_mapped & wr_priv;
  wire logic b_done = (ws_r == WS_RESP) & i_bready;

  // handshake outputs come from state
  assign o_awready = (ws_r == WS_COLLECT) & ~aw_held_r;
  assign o_wready = (ws_r == WS_COLLECT) & ~w_held_r;
  assign o_bvalid = (ws_r == WS_RESP);
  assign o_bresp = bresp_r;

  // answer: unmapped decodes, user mode is refused, else okay
  assign bresp_nxt = ~both_held ? bresp_r :
                     ~wr_mapped ? socs_pkg::RESP_DECERR :
                     ~wr_priv ? socs_pkg::RESP_SLVERR :
                     socs_pkg::RESP_OKAY;

  // held flags clear once the response is taken
  assign aw_held_nxt = b_done ? 1'b0 : (aw_held_r | aw_take);
  assign w_held_nxt = b_done ? 1'b0 : (w_held_r | w_take);

  // write sequencing
  always_comb begin
    ws_nxt = ws_r;
    case (ws_r)
      WS_COLLECT: begin
        if (both_held) begin
          ws_nxt = WS_RESP;
        end
      end
      WS_RESP: begin
        if (i_bready) begin
          ws_nxt = WS_COLLECT;
        end
      end
      default: begin
        ws_nxt = WS_COLLECT;
      end
    endcase
  end

  // write control state
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ws_r <= WS_COLLECT;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      bresp_r <= socs_pkg::RESP_OKAY;
    end else begin
      ws_r <= ws_nxt;
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      bresp_r <= bresp_nxt;
    end
  end

  // write address and data capture
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_addr_r <= 12'h000;
      aw_prot_r <= 3'h0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_addr_r <= i_awaddr;
        aw_prot_r <= i_awprot;
      end
      if (w_take) begin
        w_data_r <= i_wdata;
        w_strb_r <= i_wstrb;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // option registers

  socs_wr_if wr_port [socs_pkg::NREG] ();

  localparam logic [socs_pkg::NREG-1:0][31:0] REG_MASK = {
    socs_pkg::MASK_SEROPT, socs_pkg::MASK_TMROPT, socs_pkg::MASK_CLKSRC};
  localparam logic [socs_pkg::NREG-1:0][31:0] REG_RST = {
    socs_pkg::RST_SEROPT, socs_pkg::RST_TMROPT, socs_pkg::RST_CLKSRC};

  // one register per offset, each with its own strobe
  for (genvar i = 0; i < socs_pkg::NREG; i++) begin : g_reg
    assign wr_port[i].en = wr_do & wr_hit[i];
    assign wr_port[i].data = w_data_r;
    assign wr_port[i].strb = w_strb_r;
    socs_opt_reg #(
      .MASK(REG_MASK[i]),
      .RST(REG_RST[i])
    ) u_reg (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .wr(wr_port[i]),
      .o_q(reg_q[i])
    );
  end

  // named register views
  wire logic [31:0] clksrc_q = reg_q[0];
  wire logic [31:0] tmropt_q = reg_q[1];
  wire logic [31:0] seropt_q = reg_q[2];

  ////////////////////////////////////////////////////////////////////////
  // read channel

  wire logic ar_take = i_arvalid & o_arready;
  wire logic [2:0] rd_hit = socs_pkg::reg_hit(i_araddr);
  wire logic [31:0] rd_word = ({32{rd_hit[0]}} & clksrc_q) |
                              ({32{rd_hit[1]}} & tmropt_q) |
                              ({32{rd_hit[2]}} & seropt_q);

  assign o_arready = (rs_r == RS_IDLE);
  assign o_rvalid = (rs_r == RS_RESP);
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;

  // reads are open to any privilege; unmapped reads give zero
  assign rdata_nxt = ar_take ? rd_word : rdata_r;
  assign rresp_nxt = ~ar_take ? rresp_r :
                     (|rd_hit) ? socs_pkg::RESP_OKAY : socs_pkg::RESP_DECERR;

  // read sequencing
  always_comb begin
    rs_nxt = rs_r;
    case (rs_r)
      RS_IDLE: begin
        if (i_arvalid) begin
          rs_nxt = RS_RESP;
        end
      end
      RS_RESP: begin
        if (i_rready) begin
          rs_nxt = RS_IDLE;
        end
      end
      default: begin
        rs_nxt = RS_IDLE;
      end
    endcase
  end

  // read state and data
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rs_r <= RS_IDLE;
      rdata_r <= 32'h0000_0000;
      rresp_r <= socs_pkg::RESP_OKAY;
    end else begin
      rs_r <= rs_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // field extraction

  wire logic [1:0] ser_src = clksrc_q[socs_pkg::SER_SRC_LSB +: 2];
  wire logic [1:0] tmr_src = clksrc_q[socs_pkg::TMR_SRC_LSB +: 2];
  wire logic [2:0] cko_sel = clksrc_q[socs_pkg::CKO_SEL_LSB +: 3];
  wire logic rtc_sel = clksrc_q[socs_pkg::RTCOUT_BIT];
  wire logic t1_pin_sel = tmropt_q[socs_pkg::T1PIN_BIT];
  wire logic t0_pin_sel = tmropt_q[socs_pkg::T0PIN_BIT];
  wire logic cap_sel = tmropt_q[socs_pkg::CAP_BIT];
  wire logic od_en = seropt_q[socs_pkg::OD_BIT];

  assign o_serial_port_clock_source = ser_src;
  assign o_timer_counter_clock_source = tmr_src;
  assign o_clock_output_pin_select = cko_sel;

  ////////////////////////////////////////////////////////////////////////
  // peripheral clock muxes

  // shared source vector for the two peripheral clocks, code 0 is off
  wire logic [3:0] periph_src = {i_clock_generator_internal_ref,
                                 i_external_oscillator_ref_clock,
                                 i_fast_internal_rc_clock,
                                 1'b0};

  // serial port transmit and receive clock
  socs_clk_mux #(
    .SEL_W(2),
    .VALID(4'he)
  ) u_ser_mux (
    .i_sel(ser_src),
    .i_src(periph_src),
    .o_clk(o_serial_port_clock)
  );

  // timer counter clock
  socs_clk_mux #(
    .SEL_W(2),
    .VALID(4'he)
  ) u_tmr_mux (
    .i_sel(tmr_src),
    .i_src(periph_src),
    .o_clk(o_timer_counter_clock)
  );

  ////////////////////////////////////////////////////////////////////////
  // clock output pins

  // reserved slots 0, 1 and 5 carry no clock
  wire logic [7:0] cko_src = {i_fast_internal_rc_clock,
                              i_external_oscillator_ref_clock,
                              1'b0,
                              i_slow_internal_rc_clock,
                              i_low_power_oscillator_1khz,
                              i_clk,
                              1'b0,
                              1'b0};

  // general clock output pin
  socs_clk_mux #(
    .SEL_W(3),
    .VALID(socs_pkg::CKO_VALID)
  ) u_cko_mux (
    .i_sel(cko_sel),
    .i_src(cko_src),
    .o_clk(o_general_clock_output_pin)
  );

  // rtc clock output pin: 1 Hz tick or oscillator reference
  assign o_rtc_clock_output_pin = rtc_sel ? i_external_oscillator_ref_clock : i_rtc_1hz_clock;

  ////////////////////////////////////////////////////////////////////////
  // timer pins and capture

  // the pin function itself is set in the port control logic
  assign o_timer1_ext_clock = t1_pin_sel ? i_timer_ext_clock_input_1 : i_timer_ext_clock_input_0;
  assign o_timer0_ext_clock = t0_pin_sel ? i_timer_ext_clock_input_1 : i_timer_ext_clock_input_0;

  // capture source; left set outside capture mode it still steers comparator
  assign o_timer1_ch0_capture = cap_sel ? i_analog_comparator_output : i_timer1_channel0_input;

  ////////////////////////////////////////////////////////////////////////
  // serial transmit pin

  // registered transmit level
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_r <= 1'b1;
    end else begin
      tx_r <= i_serial_tx_data;
    end
  end

  // open drain only pulls low and releases for a high level
  assign o_serial_port_open_drain_enable = od_en;
  assign o_serial_tx_pin_o = od_en ? 1'b0 : tx_r;
  assign o_serial_tx_pin_oe_n = od_en ? tx_r : 1'b0;

endmodule : socs_clock_select
`default_nettype wire

//--- tb/socs_clock_select_asserts.sv
// socs_clock_select_asserts: bus handshake, clock mux and tx pin properties.
// assumes the port names of socs_clock_select; bound at the foot of the file.
`timescale 1ns/1ps
`default_nettype none
module socs_clock_select_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [11:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [11:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_fast_internal_rc_clock,
  input wire logic i_serial_tx_data,
  input wire logic o_serial_port_clock,
  input wire logic o_general_clock_output_pin,
  input wire logic o_serial_port_open_drain_enable,
  input wire logic o_serial_tx_pin_o,
  input wire logic o_serial_tx_pin_oe_n,
  input wire logic [1:0] o_serial_port_clock_source,
  input wire logic [2:0] o_clock_output_pin_select
);
  logic wr_map;
  logic rd_map;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////
  // address hits on the three option registers
  assign wr_map = i_awaddr == socs_pkg::OFS_CLKSRC || i_awaddr == socs_pkg::OFS_TMROPT ||
                  i_awaddr == socs_pkg::OFS_SEROPT;
  assign rd_map = i_araddr == socs_pkg::OFS_CLKSRC || i_araddr == socs_pkg::OFS_TMROPT ||
                  i_araddr == socs_pkg::OFS_SEROPT;
  ////////////////////////////////////////////////////////////////////////
  sequence s_wr_take;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_rd_take;
    i_arvalid && o_arready;
  endsequence
  property p_wr_answer;
    s_wr_take |-> ##[1:2] o_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
  property p_wr_user;
    s_wr_take ##0 (wr_map && !i_awprot[0]) |-> ##[1:2] (o_bvalid && o_bresp == socs_pkg::RESP_SLVERR);
  endproperty
  a_wr_user: assert property (p_wr_user) else $error("user write not refused");
  property p_b_hold;
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_rd_unmapped;
    s_rd_take ##0 !rd_map |-> ##[1:2] (o_rvalid && o_rresp == socs_pkg::RESP_DECERR && o_rdata == 32'h0);
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not decode error");
  property p_r_hold;
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_ser_off;
    o_serial_port_clock_source == socs_pkg::SRC_OFF |-> !o_serial_port_clock;
  endproperty
  a_ser_off: assert property (p_ser_off) else $error("gated serial clock toggles");
  property p_ser_fast;
    o_serial_port_clock_source == socs_pkg::SRC_FAST_RC |-> o_serial_port_clock == i_fast_internal_rc_clock;
  endproperty
  a_ser_fast: assert property (p_ser_fast) else $error("serial clock not fast rc");
  property p_cko_rsvd;
    !socs_pkg::CKO_VALID[o_clock_output_pin_select] |-> !o_general_clock_output_pin;
  endproperty
  a_cko_rsvd: assert property (p_cko_rsvd) else $error("reserved clock out code not low");
  property p_od_pin;
    o_serial_port_open_drain_enable |-> !o_serial_tx_pin_o;
  endproperty
  a_od_pin: assert property (p_od_pin) else $error("open drain pin drives high");
  property p_push_pull;
    !o_serial_port_open_drain_enable |-> !o_serial_tx_pin_oe_n && o_serial_tx_pin_o == $past(i_serial_tx_data);
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push pull pin wrong");
endmodule : socs_clock_select_chk
bind socs_clock_select socs_clock_select_chk u_chk (.i_clk, .i_rst, .i_awaddr, .i_awprot, .i_awvalid, .o_awready,
  .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
  .o_rvalid, .i_rready, .i_fast_internal_rc_clock, .i_serial_tx_data, .o_serial_port_clock,
  .o_general_clock_output_pin, .o_serial_port_open_drain_enable, .o_serial_tx_pin_o, .o_serial_tx_pin_oe_n,
  .o_serial_port_clock_source, .o_clock_output_pin_select);
`default_nettype wire

//--- tb/socs_periph_model.sv
// socs_periph_model: clock sources, timer pins and capture inputs around the block.
// assumes nothing of the bus clock; every source runs free on its own period.
`timescale 1ns/1ps
`default_nettype none
module socs_periph_model (
  output logic [9:0] o_src
);
  int t;
  ////////////////////////////////////////////////////////////////////////
  // sources toggle on whole nanoseconds, pins arrive already routed to their timer function
  initial begin
    o_src = 10'h155;
    t = 0;
    forever begin
      #1;
      t++;
      for (int k = 0; k < 10; k++) begin
        if (t % (3 + 4 * k) == 0) begin
          o_src[k] = ~o_src[k];
        end
      end
    end
  end
endmodule : socs_periph_model
`default_nettype wire

//--- tb/socs_clock_select_tb_top.sv
// socs_clock_select_tb_top: register traffic, mux and tx pin checks.
// assumes the peripheral model drives every clock source and pin input.
`timescale 1ns/1ps
`default_nettype none
module socs_clock_select_tb_top;
  logic i_clk, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, tx, tx_old;
  logic [11:0] i_awaddr, i_araddr;
  logic [2:0] i_awprot, i_arprot, cko_f;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0] i_wstrb;
  logic [9:0] src;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, ser_ck, tmr_ck, cko, rtc, t0, t1, cap, od, pin_o, pin_oe_n;
  logic [1:0] o_bresp, o_rresp, ser_f, tmr_f;
  logic [31:0] sh [3];
  logic [1:0] exp_b [$];
  logic [33:0] exp_r [$];
  int fail_count = 0, cmp_count = 0, cyc = 0, seed = 90854;
  localparam logic [11:0] ADR [4] = '{socs_pkg::OFS_CLKSRC, socs_pkg::OFS_TMROPT, socs_pkg::OFS_SEROPT, 12'h008};
  localparam logic [31:0] MSK [3] = '{socs_pkg::MASK_CLKSRC, socs_pkg::MASK_TMROPT, socs_pkg::MASK_SEROPT};
  socs_clock_select u_dut (
    .i_clk, .i_rst, .i_awaddr, .i_awprot, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready,
    .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arprot, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
    .i_rready, .i_fast_internal_rc_clock(src[0]), .i_external_oscillator_ref_clock(src[1]),
    .i_clock_generator_internal_ref(src[2]), .i_slow_internal_rc_clock(src[3]), .i_low_power_oscillator_1khz(src[4]),
    .i_rtc_1hz_clock(src[5]), .i_timer_ext_clock_input_0(src[6]), .i_timer_ext_clock_input_1(src[7]),
    .i_timer1_channel0_input(src[8]), .i_analog_comparator_output(src[9]), .i_serial_tx_data(tx),
    .o_serial_port_clock(ser_ck), .o_timer_counter_clock(tmr_ck), .o_general_clock_output_pin(cko),
    .o_rtc_clock_output_pin(rtc), .o_timer0_ext_clock(t0), .o_timer1_ext_clock(t1), .o_timer1_ch0_capture(cap),
    .o_serial_port_open_drain_enable(od), .o_serial_tx_pin_o(pin_o), .o_serial_tx_pin_oe_n(pin_oe_n),
    .o_serial_port_clock_source(ser_f), .o_timer_counter_clock_source(tmr_f), .o_clock_output_pin_select(cko_f)
  );
  socs_periph_model u_model (.o_src(src));
  ////////////////////////////////////////////////////////////////////////
  // bus clock, random tx data and the hang limit
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    tx_old <= tx;
    if (!i_rst) begin
      tx <= ($random(seed) & 32'h1) != 0;
    end
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [33:0] got, input logic [33:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
      fail_count++;
    end
  endtask : cmp
  // one write, both channels offered together, response expected in the queue
  task automatic wr(input int i, input logic [2:0] p, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] bm;
    logic ad, wd;
    bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    ad = 1'b0;
    wd = 1'b0;
    if (i == 3) begin
      exp_b.push_back(socs_pkg::RESP_DECERR);
    end else if (!p[0]) begin
      exp_b.push_back(socs_pkg::RESP_SLVERR);
    end else begin
      exp_b.push_back(socs_pkg::RESP_OKAY);
      sh[i] = (sh[i] & ~(bm & MSK[i])) | (d & bm & MSK[i]);
    end
    @(posedge i_clk);
    i_awaddr <= ADR[i];
    i_awprot <= p;
    i_wdata <= d;
    i_wstrb <= s;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge i_clk);
      if (o_awready && !ad) begin
        ad = 1'b1;
        i_awvalid <= 1'b0;
      end
      if (o_wready && !wd) begin
        wd = 1'b1;
        i_wvalid <= 1'b0;
      end
    end
    do @(posedge i_clk); while (!o_bvalid);
    i_bready <= 1'b0;
  endtask : wr
  // one read, expected word noted before the request goes out
  task automatic rd(input int i, input logic [2:0] p);
    exp_r.push_back(i == 3 ? {socs_pkg::RESP_DECERR, 32'h0} : {socs_pkg::RESP_OKAY, sh[i]});
    @(posedge i_clk);
    i_araddr <= ADR[i];
    i_arprot <= p;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do @(posedge i_clk); while (!o_arready);
    i_arvalid <= 1'b0;
    do @(posedge i_clk); while (!o_rvalid);
    i_rready <= 1'b0;
  endtask : rd
  // samples every steered output off the source edges, four times in one bus cycle
  task automatic chk_pins();
    logic [31:0] s, t;
    logic [3:0] pk;
    logic [7:0] ck;
    logic oe;
    s = sh[0];
    t = sh[1];
    oe = sh[2][16];
    repeat (4) begin
      #23.3;
      pk = {src[2:0], 1'b0};
      ck = {src[0], src[1], 1'b0, src[3], src[4], i_clk, 2'b00};
      cmp(ser_ck, pk[s[27:26]], "serial clock");
      cmp(tmr_ck, pk[s[25:24]], "timer clock");
      cmp(cko, ck[s[7:5]], "clock out pin");
      cmp(rtc, s[4] ? src[1] : src[5], "rtc pin");
      cmp(t1, t[25] ? src[7] : src[6], "timer1 pin");
      cmp(t0, t[24] ? src[7] : src[6], "timer0 pin");
      cmp(cap, t[18] ? src[9] : src[8], "capture source");
      cmp({od, pin_o, pin_oe_n}, {oe, !oe && tx_old, oe && tx_old}, "tx pin");
      cmp({ser_f, tmr_f, cko_f}, {s[27:24], s[7:5]}, "fields");
    end
  endtask : chk_pins
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////
  // watcher: every bus answer is matched against the oldest note
  always @(posedge i_clk) begin
    if (o_bvalid && i_bready) begin
      cmp(o_bresp, exp_b.pop_front(), "write response");
    end
    if (o_rvalid && i_rready) begin
      cmp({o_rresp, o_rdata}, exp_r.pop_front(), "read data");
    end
  end
  // main sequence: reset values, every code, random traffic
  initial begin
    {i_rst, tx, tx_old} = 3'h7;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
    {i_awaddr, i_araddr, i_awprot, i_arprot, i_wdata, i_wstrb} = '0;
    sh = '{32'h0, 32'h0, 32'h0};
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(i, 3'h0);
    end
    chk_pins();
    for (int c = 0; c < 8; c++) begin
      wr(0, 3'h1, {4'hf, 2'(c), 2'(c + 1), 16'hffff, 3'(c), c[0], 4'hf}, 4'hf);
      wr(1, 3'h1, {6'h3f, 2'(c), 5'h1f, c[2], 18'h3ffff}, 4'hf);
      wr(2, 3'h1, {15'h7fff, c[0], 16'hffff}, 4'hf);
      chk_pins();
      for (int i = 0; i < 3; i++) begin
        rd(i, 3'(c));
      end
    end
    for (int n = 0; n < 24; n++) begin
      int i;
      i = ($random(seed) & 32'h7fff_ffff) % 4;
      wr(i, 3'($random(seed)), $random(seed), 4'($random(seed)));
      rd(i, 3'h2);
      chk_pins();
    end
    wr(1, 3'h1, 32'h0, 4'hf); // capture source back to the channel once capture ends
    chk_pins();
    wrap_up();
  end
endmodule : socs_clock_select_tb_top
`default_nettype wire
